// ### verilog/ise_engine.sv
// Slave engine of a two-wire serial interface with its flags.
// Assumes pins are sampled here; software access arrives as pulses.
`timescale 1ns/1ps
// Notes on behaviour
// - Reset into slave mode; master mode only after a software START request.
// - Master mode drops back to slave on lost arbitration or STOP.
// - Receiver returns acknowledge in the ninth clock after eight data clocks.
// - After START shift address; compare own one, own two, general call.
// - Ten-bit mode compares header 11110xx0 with the two address high bits.
// - On mismatch stay silent and idle until the next START.
// - Ten-bit header match acknowledges when enabled, then awaits low byte.
// - Address match acknowledges when enabled, sets matched flag, may interrupt.
// - With dual addressing a flag tells which own address matched.
// - Ten-bit slave receives; transmits only after restart with read header.
// - Direction flag shows whether the slave transmits or receives.
// - Transmitter holds clock low until matched flag clears and data written.
// - Matched flag clears on status one read then status two read.
// - Acknowledge from master sets transmit-empty; interrupt with both enables.
// - Empty transmitter at byte end sets byte-finished, holds clock low.
// - Master not acknowledging sets failure flag; software clears by writing zero.
// - Receiver acknowledges when enabled, sets receive-not-empty, may interrupt.
// - Unread data at next byte end sets byte-finished, holds clock low.
// - Reading data register clears receive-not-empty.
// - STOP to this slave sets stop flag; status one read, control write clear.
// - Event and error sources share one interrupt output.
module ise_engine #(
    parameter int CLK_MHZ = ise_pkg::SYS_CLK_MHZ
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_b,
    input  wire logic       i_scl,
    output logic            o_scl,
    output logic            o_scl_oe,
    input  wire logic       i_sda,
    output logic            o_sda,
    output logic            o_sda_oe,
    input  wire logic [9:0] i_own_address_one,
    input  wire logic [6:0] i_own_address_two,
    input  wire logic       i_addr10_enable,
    input  wire logic       i_dual_address_enable,
    input  wire logic       i_general_call_enable,
    input  wire logic       i_ack_enable,
    input  wire logic       i_event_interrupt_enable,
    input  wire logic       i_buffer_interrupt_enable,
    input  wire logic       i_error_interrupt_enable,
    input  wire logic       i_start_request,
    input  wire logic       i_stop_generated,
    input  wire logic       i_arbitration_lost,
    input  wire logic       i_status_one_rd,
    input  wire logic       i_status_two_rd,
    input  wire logic       i_data_rd,
    input  wire logic       i_data_wr,
    input  wire logic [7:0] i_data_wdata,
    input  wire logic       i_control_one_wr,
    input  wire logic       i_ack_failure_clr,
    output logic [7:0]      o_data_register,
    output logic            o_master_mode,
    output logic            o_address_matched_flag,
    output logic            o_dual_match_flag,
    output logic            o_direction_flag,
    output logic            o_transmit_empty_flag,
    output logic            o_byte_finished_flag,
    output logic            o_acknowledge_failure_flag,
    output logic            o_receive_not_empty_flag,
    output logic            o_stop_detected_flag,
    output logic            o_irq
);
    // Input clock floor for the 400 kHz rate, the highest of the floors
    // clock floor check
    if (CLK_MHZ < ise_pkg::MIN_CLK_FM400_MHZ) begin : g_clk_chk
        $error("Module clock too slow for the serial rates");
    end

    typedef struct packed {
        ise_pkg::ise_state_type st;
        logic       scl_p;
        logic       sda_p;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic       ack_ph;
        logic       acked;
        logic       hold;
        logic       sda_oe;
        logic       scl_oe;
        logic       sel;
        logic       hdr_ok;
        logic       dir;
        logic       master;
        logic       status_register_one_seen;
        logic       txfull;
        logic [7:0] dat;
        logic       address_matched_flag;
        logic       dualf;
        logic       txe;
        logic       byte_finished_flag;
        logic       ackf;
        logic       rxne;
        logic       stop_detected_flag;
    } ise_main_type;

    ise_main_type q;
    ise_main_type n;

    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic hdr_hit;
    logic gc_hit;
    logic own1_hit;
    logic own2_hit;
    logic byte_end;

    ise_sync u_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (i_rst_b),
        .i_scl     (i_scl),
        .i_sda     (i_sda),
        .o_scl     (scl_s),
        .o_sda     (sda_s)
    );

    assign scl_rise  = scl_s & ~q.scl_p;
    assign scl_fall  = ~scl_s & q.scl_p;
    assign bus_start = scl_s & q.scl_p & q.sda_p & ~sda_s;
    assign bus_stop  = scl_s & q.scl_p & ~q.sda_p & sda_s;
    assign byte_end  = scl_fall & ~q.ack_ph & (q.cnt == ise_pkg::BITS_PER_BYTE);

    // Address comparators
    // ten-bit header compare
    assign hdr_hit  = i_addr10_enable & (q.sh[7:3] == ise_pkg::HDR10_PREFIX)
                      & (q.sh[2:1] == i_own_address_one[9:8]);
    assign gc_hit   = i_general_call_enable & (q.sh[7:1] == ise_pkg::GEN_CALL_ADDR);
    assign own1_hit = ~i_addr10_enable & (q.sh[7:1] == i_own_address_one[6:0]);
    assign own2_hit = i_dual_address_enable & (q.sh[7:1] == i_own_address_two);

    always_comb begin
        n       = q;
        n.scl_p = scl_s;
        n.sda_p = sda_s;

        // Status read order tracking
        if (i_status_two_rd | i_data_wr | i_data_rd | i_control_one_wr) begin
            n.status_register_one_seen = 1'b0;
        end
        if (i_status_one_rd) begin
            n.status_register_one_seen = 1'b1;
        end
        if (i_status_two_rd & q.status_register_one_seen) begin
            n.address_matched_flag = 1'b0;
        end
        if (q.status_register_one_seen & (i_data_wr | i_data_rd)) begin
            n.byte_finished_flag = 1'b0;
        end
        if (q.status_register_one_seen & i_control_one_wr) begin
            n.stop_detected_flag = 1'b0;
        end
        if (i_ack_failure_clr) begin
            n.ackf = 1'b0;
        end
        if (i_data_rd) begin
            n.rxne = 1'b0;
        end
        if (i_data_wr) begin
            n.dat    = i_data_wdata;
            n.txfull = 1'b1;
            n.txe    = 1'b0;
        end

        if (i_start_request) begin
            n.master = 1'b1;
        end
        if (i_arbitration_lost | i_stop_generated) begin
            n.master = 1'b0;
        end

        if (bus_start) begin
            n.st     = ise_pkg::ST_ADDR;
            n.cnt    = ise_pkg::CNT_RESET;
            n.ack_ph = 1'b0;
            n.sda_oe = 1'b0;
            n.scl_oe = 1'b0;
            n.hold   = 1'b0;
        end else if (bus_stop) begin
            if (q.sel) begin
                n.stop_detected_flag = 1'b1;
            end
            n.st     = ise_pkg::ST_IDLE;
            n.sel    = 1'b0;
            n.hdr_ok = 1'b0;
            n.ack_ph = 1'b0;
            n.sda_oe = 1'b0;
            n.scl_oe = 1'b0;
            n.hold   = 1'b0;
        end else if (q.st != ise_pkg::ST_IDLE) begin
            if (scl_rise & ~q.ack_ph) begin
                n.sh  = {q.sh[6:0], sda_s};
                n.cnt = q.cnt + 4'h1;
            end
            if (scl_rise & q.ack_ph & ~q.sda_oe & (q.st == ise_pkg::ST_TX)) begin
                n.acked = ~sda_s;
                if (sda_s) begin
                    n.ackf = 1'b1;
                end else begin
                    n.txe = 1'b1;
                end
            end
            if (scl_fall & q.ack_ph) begin
                n.ack_ph = 1'b0;
                n.sda_oe = 1'b0;
                n.cnt    = ise_pkg::CNT_RESET;
                if ((q.st == ise_pkg::ST_TX) & ~q.acked) begin
                    n.st = ise_pkg::ST_IDLE;
                end else if ((q.st == ise_pkg::ST_TX) | q.address_matched_flag) begin
                    n.scl_oe = 1'b1;
                    n.hold   = 1'b1;
                    if ((q.st == ise_pkg::ST_TX) & ~q.address_matched_flag & ~q.txfull) begin
                        n.byte_finished_flag = 1'b1;
                    end
                end
            end else if (byte_end) begin
                case (q.st)
                    ise_pkg::ST_ADDR: begin
                        if (q.master) begin
                            n.st = ise_pkg::ST_IDLE;
                        end else if (hdr_hit & ~q.sh[0]) begin
                            n.st     = ise_pkg::ST_ADDR_LO;
                            n.ack_ph = 1'b1;
                            n.sda_oe = i_ack_enable;
                        end else if (own1_hit | own2_hit | gc_hit | (hdr_hit & q.sh[0] & q.hdr_ok)) begin
                            n.sel    = 1'b1;
                            n.address_matched_flag  = 1'b1;
                            n.dualf  = own2_hit & ~own1_hit;
                            n.dir    = q.sh[0];
                            n.acked  = 1'b1;
                            n.txe    = q.sh[0] & ~q.txfull;
                            n.st     = q.sh[0] ? ise_pkg::ST_TX : ise_pkg::ST_RX;
                            n.ack_ph = 1'b1;
                            n.sda_oe = i_ack_enable;
                        end else begin
                            n.st = ise_pkg::ST_IDLE;
                        end
                    end
                    ise_pkg::ST_ADDR_LO: begin
                        if (q.sh == i_own_address_one[7:0]) begin
                            n.sel    = 1'b1;
                            n.hdr_ok = 1'b1;
                            n.address_matched_flag  = 1'b1;
                            n.dualf  = 1'b0;
                            n.dir    = 1'b0;
                            n.st     = ise_pkg::ST_RX;
                            n.ack_ph = 1'b1;
                            n.sda_oe = i_ack_enable;
                        end else begin
                            n.st = ise_pkg::ST_IDLE;
                        end
                    end
                    ise_pkg::ST_RX: begin
                        if (q.rxne) begin
                            n.byte_finished_flag    = 1'b1;
                            n.scl_oe = 1'b1;
                            n.hold   = 1'b1;
                        end else begin
                            n.dat    = q.sh;
                            n.rxne   = 1'b1;
                            n.ack_ph = 1'b1;
                            n.sda_oe = i_ack_enable;
                        end
                    end
                    ise_pkg::ST_TX: begin
                        n.ack_ph = 1'b1;
                        n.sda_oe = 1'b0;
                    end
                    default: begin
                        n.st = ise_pkg::ST_IDLE;
                    end
                endcase
            end else if (scl_fall & (q.st == ise_pkg::ST_TX)) begin
                n.sda_oe = ~q.sh[7];
            end

            // Clock stretch release
            if (q.hold) begin
                if (q.st == ise_pkg::ST_TX) begin
                    if (~q.address_matched_flag & q.txfull) begin
                        n.sh     = q.dat;
                        n.sda_oe = ~q.dat[7];
                        n.txfull = 1'b0;
                        n.scl_oe = 1'b0;
                        n.hold   = 1'b0;
                    end
                end else if (q.cnt == ise_pkg::BITS_PER_BYTE) begin
                    if (~q.rxne) begin
                        n.dat    = q.sh;
                        n.rxne   = 1'b1;
                        n.ack_ph = 1'b1;
                        n.sda_oe = i_ack_enable;
                        n.scl_oe = 1'b0;
                        n.hold   = 1'b0;
                    end
                end else if (~q.address_matched_flag) begin
                    n.scl_oe = 1'b0;
                    n.hold   = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            q       <= '0;
            q.st    <= ise_pkg::ST_IDLE;
            q.scl_p <= 1'b1;
            q.sda_p <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign o_scl                      = 1'b0;
    assign o_sda                      = 1'b0;
    assign o_scl_oe                   = q.scl_oe;
    assign o_sda_oe                   = q.sda_oe;
    assign o_data_register            = q.dat;
    assign o_master_mode              = q.master;
    assign o_address_matched_flag     = q.address_matched_flag;
    assign o_dual_match_flag          = q.dualf;
    assign o_direction_flag           = q.dir;
    assign o_transmit_empty_flag      = q.txe;
    assign o_byte_finished_flag       = q.byte_finished_flag;
    assign o_acknowledge_failure_flag = q.ackf;
    assign o_receive_not_empty_flag   = q.rxne;
    assign o_stop_detected_flag       = q.stop_detected_flag;

    assign o_irq = (i_event_interrupt_enable & (q.address_matched_flag | q.stop_detected_flag | q.byte_finished_flag))
                   | (i_event_interrupt_enable & i_buffer_interrupt_enable & (q.txe | q.rxne))
                   | (i_error_interrupt_enable & q.ackf);

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);

    AST_MASTER_ONLY_BY_REQUEST: assert property (
        $rose(q.master) |-> $past(i_start_request))
        else $error("Master mode entered without a start request");

    AST_FALLBACK_TO_SLAVE: assert property (
        (i_arbitration_lost | i_stop_generated) |=> !q.master)
        else $error("Master mode kept after stop or lost arbitration");

    AST_ACK_HELD: assert property (
        (q.ack_ph && q.sda_oe && !scl_fall && !bus_start && !bus_stop) |=> q.sda_oe)
        else $error("Acknowledge released before end of ninth clock");

    AST_MISMATCH_IDLE: assert property (
        (q.st == ise_pkg::ST_ADDR && byte_end && !bus_start && !bus_stop
         && !(own1_hit | own2_hit | gc_hit | hdr_hit))
        |=> (q.st == ise_pkg::ST_IDLE) && !q.sda_oe)
        else $error("Device answered a foreign address");

    AST_MATCH_FLAG: assert property (
        (q.st == ise_pkg::ST_ADDR && byte_end && !q.master && !bus_start && !bus_stop
         && (own1_hit | own2_hit)) |=> q.address_matched_flag && q.ack_ph && (q.sda_oe == $past(i_ack_enable)))
        else $error("Address match not flagged or acknowledged");

    AST_MATCH_CLEAR: assert property (
        (q.status_register_one_seen && i_status_two_rd && !scl_fall) |=> !q.address_matched_flag)
        else $error("Matched flag survived the clearing sequence");

    AST_TX_STRETCH: assert property (
        (q.st == ise_pkg::ST_TX && q.hold && (q.address_matched_flag || !q.txfull)) |=> q.scl_oe)
        else $error("Transmitter released clock before data was ready");

    AST_RX_OVERRUN: assert property (
        (q.st == ise_pkg::ST_RX && byte_end && q.rxne && !i_data_rd && !bus_start && !bus_stop)
        |=> q.byte_finished_flag && q.scl_oe ##1 q.scl_oe)
        else $error("Overrun did not stall the clock");

    AST_RXNE_CLEAR: assert property (
        (i_data_rd && !scl_fall && !q.hold) |=> !q.rxne)
        else $error("Data read left receive flag set");

    AST_NACK_FLAG: assert property (
        (q.st == ise_pkg::ST_TX && q.ack_ph && scl_rise && !q.sda_oe && sda_s
         && !bus_start && !bus_stop) |=> q.ackf)
        else $error("Missing acknowledge not flagged");

    AST_STOP_FLAG: assert property (
        (bus_stop && q.sel) |=> q.stop_detected_flag && (q.st == ise_pkg::ST_IDLE))
        else $error("Stop to this slave not flagged");

    AST_ERR_IRQ: assert property (
        (q.ackf && i_error_interrupt_enable) |-> o_irq)
        else $error("Error flag did not reach interrupt");

    COV_ADDR_MATCH: cover property ($rose(q.address_matched_flag));
    COV_TX_ACKED: cover property ($rose(q.txe) && q.st == ise_pkg::ST_TX);
    COV_RX_BYTE: cover property ($rose(q.rxne));
    COV_STOP: cover property ($rose(q.stop_detected_flag));
endmodule

// ### verilog/ise_pkg.sv
// Constants shared by the two-wire slave engine files.
// Assumes one system clock and a synchronous active-low reset.
package ise_pkg;
    localparam int         SYS_CLK_MHZ       = 250;
    localparam int         MIN_CLK_STD_MHZ   = 2;
    localparam int         MIN_CLK_FM1M_MHZ  = 3;
    localparam int         MIN_CLK_FM400_MHZ = 10;
    localparam logic [4:0] HDR10_PREFIX      = 5'h1e;
    localparam logic [6:0] GEN_CALL_ADDR     = 7'h00;
    localparam logic [3:0] BITS_PER_BYTE     = 4'h8;
    localparam logic [3:0] CNT_RESET         = 4'h0;
    localparam logic [7:0] DATA_RESET        = 8'h00;
    localparam logic [1:0] SYNC_RESET        = 2'h3;

    typedef enum logic [4:0] {
        ST_IDLE    = 5'h01,
        ST_ADDR    = 5'h02,
        ST_ADDR_LO = 5'h04,
        ST_RX      = 5'h08,
        ST_TX      = 5'h10
    } ise_state_type;
endpackage

// ### verilog/ise_sync.sv
// Two-stage synchroniser for the clock and data line inputs.
// Assumes the bus pins are asynchronous to i_clk_sys.
`timescale 1ns/1ps
module ise_sync (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_b,
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda
);
    typedef struct packed {
        logic [1:0] scl;
        logic [1:0] sda;
    } ise_sync_type;

    ise_sync_type s_q;
    ise_sync_type s_d;

    always_comb begin
        s_d     = s_q;
        s_d.scl = {s_q.scl[0], i_scl};
        s_d.sda = {s_q.sda[0], i_sda};
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            s_q <= {ise_pkg::SYNC_RESET, ise_pkg::SYNC_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_scl = s_q.scl[1];
    assign o_sda = s_q.sda[1];
endmodule

// ### verification/ise_master_model.sv
// Two-wire bus master model driving open-drain clock and data lines.
// Assumes the bench resolves both lines with pull-ups and feeds them back.
`timescale 1ns/1ps
module ise_master_model (
    input  wire logic i_clk_sys,
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_scl_oe,
    output logic      o_sda_oe
);
    localparam int HALF = 10;

    initial begin
        o_scl_oe = 1'b0;
        o_sda_oe = 1'b0;
    end

    task automatic tk(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask

    // Clock high phase, waits out any stretching by the slave
    task automatic hi();
        o_scl_oe <= 1'b0;
        do @(posedge i_clk_sys); while (i_scl !== 1'b1);
        tk(HALF - 1);
    endtask

    // START when s is high, STOP when low, around one clock high phase
    task automatic cond(input logic s);
        tk(3);
        o_sda_oe <= ~s;
        tk(HALF);
        hi();
        o_sda_oe <= s;
        tk(HALF);
        o_scl_oe <= s;
    endtask

    // Eight data clocks, ninth for acknowledge
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            tk(3);
            o_sda_oe <= ~d[i];
            tk(HALF - 3);
            hi();
            q[i] = i_sda;
            o_scl_oe <= 1'b1;
        end
    endtask
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the two-wire slave engine.
// Assumes a bus master model on the lines and pulsed software strobes.
`timescale 1ns/1ps
module tb_top;
    localparam int S1 = 0, S2 = 1, DRD = 2, DWR = 3, C1W = 4, AFC = 5, STQ = 6, STG = 7, ARB = 8;
    logic        clk, rst_b, a10, dual, gc, acken, evie, bufie, errie;
    logic        m_scl_oe, m_sda_oe, d_scl_oe, d_sda_oe, d_scl, d_sda;
    logic        mm, amf, dmf, dirf, txe, byte_finished_flag, afl, rxne, stf, irq;
    logic [9:0]  own1;
    logic [6:0]  own2;
    logic [7:0]  wd, dreg, d;
    logic [8:0]  sb, r;
    logic [31:0] rs;
    int          err_count, checks_done, cyc;
    wire         scl_w = ~m_scl_oe & (~d_scl_oe | d_scl);
    wire         sda_w = ~m_sda_oe & (~d_sda_oe | d_sda);

    // Engine set for a 250 MHz input clock
    ise_engine #(.CLK_MHZ(250)) u_dut (
        .i_clk_sys(clk), .i_rst_b(rst_b), .i_scl(scl_w), .o_scl(d_scl), .o_scl_oe(d_scl_oe),
        .i_sda(sda_w), .o_sda(d_sda), .o_sda_oe(d_sda_oe), .i_own_address_one(own1),
        .i_own_address_two(own2), .i_addr10_enable(a10), .i_dual_address_enable(dual),
        .i_general_call_enable(gc), .i_ack_enable(acken), .i_event_interrupt_enable(evie),
        .i_buffer_interrupt_enable(bufie), .i_error_interrupt_enable(errie),
        .i_start_request(sb[STQ]), .i_stop_generated(sb[STG]), .i_arbitration_lost(sb[ARB]),
        .i_status_one_rd(sb[S1]), .i_status_two_rd(sb[S2]), .i_data_rd(sb[DRD]),
        .i_data_wr(sb[DWR]), .i_data_wdata(wd), .i_control_one_wr(sb[C1W]),
        .i_ack_failure_clr(sb[AFC]), .o_data_register(dreg), .o_master_mode(mm),
        .o_address_matched_flag(amf), .o_dual_match_flag(dmf), .o_direction_flag(dirf),
        .o_transmit_empty_flag(txe), .o_byte_finished_flag(byte_finished_flag),
        .o_acknowledge_failure_flag(afl), .o_receive_not_empty_flag(rxne),
        .o_stop_detected_flag(stf), .o_irq(irq)
    );

    ise_master_model m (
        .i_clk_sys(clk), .i_scl(scl_w), .i_sda(sda_w), .o_scl_oe(m_scl_oe), .o_sda_oe(m_sda_oe)
    );

    always #2 clk = ~clk;

    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle software strobe, flags read one edge later
    task automatic sw(input int k, input logic [7:0] v = 8'h00);
        @(posedge clk);
        sb <= 9'h001 << k;
        wd <= v;
        @(posedge clk);
        sb <= 9'h000;
        #1;
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Ceiling far above the few thousand cycles the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            stop_test();
        end
    end

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        sb = 9'h000;
        wd = 8'h00;
        rs = 32'h000082ef;
        err_count = 0;
        checks_done = 0;
        cyc = 0;
        own1 = 10'(xs()) | 10'h001;
        own2 = own1[6:0] ^ 7'h10;
        {a10, dual, gc, acken, evie, bufie, errie} = 7'(xs());
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        // Random enables while every flag is clear
        chk(16'({mm, amf, dirf, txe, byte_finished_flag, afl, rxne, stf, irq}), 16'h0000);
        sw(STQ);
        chk(16'(mm), 16'h0001);
        sw(STG);
        chk(16'(mm), 16'h0000);
        sw(STQ);
        sw(ARB);
        chk(16'(mm), 16'h0000);
        $display("test mode done");
        @(posedge clk);
        {a10, dual, gc, acken, bufie, errie} <= 6'h04;
        evie <= 1'b1;
        m.cond(1'b1);
        m.xfer({own1[6:0], 2'b01}, r);
        chk(16'({r[0], amf, dirf, dmf, irq}), 16'h0009);
        sw(S1);
        sw(S2);
        chk(16'(amf), 16'h0000);
        d = 8'(xs());
        m.xfer({d, 1'b1}, r);
        chk(16'({r[0], rxne, irq, dreg}), {5'h00, 3'h2, d});
        fork
            m.xfer({~d, 1'b1}, r);
            begin
                repeat (400) @(posedge clk);
                #1;
                chk(16'({byte_finished_flag, scl_w}), 16'h0002);
                sw(S1);
                sw(DRD);
            end
        join
        chk(16'({r[0], dreg}), {8'h00, ~d});
        sw(DRD);
        chk(16'({byte_finished_flag, rxne}), 16'h0000);
        m.cond(1'b0);
        chk(16'({stf, irq}), 16'h0003);
        sw(S1);
        sw(C1W);
        chk(16'(stf), 16'h0000);
        m.cond(1'b1);
        m.xfer({own1[6:0] ^ 7'h04, 2'b01}, r);
        chk(16'({r[0], amf}), 16'h0002);
        m.xfer({own1[6:0], 2'b01}, r);
        chk(16'({r[0], amf}), 16'h0002);
        m.cond(1'b0);
        chk(16'(stf), 16'h0000);
        dual <= 1'b1;
        gc <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            // Random acknowledge enable, then a forced silent match
            acken <= (i == 0) ? 1'(xs()) : 1'b0;
            m.cond(1'b1);
            m.xfer({(i == 0) ? own2 : 7'h00, 2'b01}, r);
            chk(16'({r[0], dmf}), {14'h0000, ~acken, i == 0});
            sw(S1);
            sw(S2);
            m.cond(1'b0);
            sw(S1);
            sw(C1W);
        end
        $display("test receive done");
        bufie <= 1'b1;
        acken <= 1'b1;
        d = 8'(xs());
        m.cond(1'b1);
        m.xfer({own1[6:0], 2'b11}, r);
        chk(16'({r[0], amf, dirf, txe}), 16'h0007);
        fork
            m.xfer(9'h1fe, r);
            begin
                repeat (60) @(posedge clk);
                #1;
                chk(16'(scl_w), 16'h0000);
                sw(S1);
                sw(S2);
                sw(DWR, d);
            end
        join
        chk(16'({r, txe, irq}), {5'h00, d, 3'h3});
        errie <= 1'b1;
        fork
            m.xfer(9'h1ff, r);
            begin
                repeat (60) @(posedge clk);
                #1;
                chk(16'({byte_finished_flag, scl_w}), 16'h0002);
                sw(S1);
                sw(DWR, ~d);
            end
        join
        chk(16'({r, afl}), {6'h00, ~d, 2'h3});
        evie <= 1'b0;
        #1;
        chk(16'(irq), 16'h0001);
        sw(AFC);
        chk(16'({afl, irq}), 16'h0000);
        evie <= 1'b1;
        m.cond(1'b0);
        $display("test transmit done");
        a10 <= 1'b1;
        dual <= 1'b0;
        m.cond(1'b1);
        m.xfer({5'h1e, ~own1[9:8], 2'b01}, r);
        chk(16'(r[0]), 16'h0001);
        m.cond(1'b1);
        m.xfer({5'h1e, own1[9:8], 2'b01}, r);
        chk(16'({r[0], amf}), 16'h0000);
        m.xfer({own1[7:0], 1'b1}, r);
        chk(16'({r[0], amf, dirf}), 16'h0002);
        sw(S1);
        sw(S2);
        m.cond(1'b1);
        m.xfer({5'h1e, own1[9:8], 2'b11}, r);
        chk(16'({r[0], dirf}), 16'h0001);
        fork
            m.xfer(9'h1ff, r);
            begin
                sw(S1);
                sw(S2);
                sw(DWR, d);
            end
        join
        chk(16'(r[8:1]), 16'(d));
        sw(AFC);
        m.cond(1'b0);
        $display("test ten bit done");
        stop_test();
    end
endmodule
